// ===== design/dpsm_cfg_if.sv
// Interface carrying the decoded node address and baud rate
// from the switch decoder to the state machine top.
// Assumes the decoder drives every signal from flip-flops.
`timescale 1ns/1ps
`default_nettype none
interface dpsm_cfg_if;
  logic [6:0] node_id;
  logic       node_ok;
  logic       from_pc;
  logic [2:0] baud_sel;
  logic       baud_ok;

  modport dec
  (
    output node_id, node_ok, from_pc, baud_sel, baud_ok
  );
  modport core
  (
    input node_id, node_ok, from_pc, baud_sel, baud_ok
  );
endinterface
`default_nettype wire

// ===== design/dpsm_pkg.sv
// Package for the drive power state machine: register map, field layout,
// command codes, reset values and the state type.
// Assumes a 32-bit APB register bus with byte addresses in paddr.
package dpsm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_QSOPT  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_PCNODE = 8'h10;
  localparam logic [7:0] OFF_PARAM  = 8'h14;

  // Host commands, written to the command register
  localparam logic [2:0] CMD_NONE     = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_SWON     = 3'h2;
  localparam logic [2:0] CMD_DISVOLT  = 3'h3;
  localparam logic [2:0] CMD_QSTOP    = 3'h4;
  localparam logic [2:0] CMD_DISOP    = 3'h5;
  localparam logic [2:0] CMD_ENOP     = 3'h6;
  localparam logic [2:0] CMD_FRESET   = 3'h7;

  // Quick stop option code handling
  localparam logic [15:0] QSOPT_RST     = 16'h0002;
  localparam logic [15:0] QSOPT_STAY    = 16'h0005;
  localparam logic [15:0] QSOPT_RET_MIN = 16'h0005;
  localparam logic [15:0] QSOPT_RET_MAX = 16'h0008;

  localparam logic [6:0] PCNODE_RST = 7'h01;

  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_POWER     = 3;
  localparam int ST_DRIVE     = 4;
  localparam int ST_QSRUN     = 5;
  localparam int ST_FRRUN     = 6;
  localparam int ST_COMM      = 7;
  localparam int ST_FAULTIN   = 8;
  localparam int ST_PARAMOK   = 9;

  // Config register fields
  localparam int CF_NODE_LSB = 0;
  localparam int CF_NODEOK   = 7;
  localparam int CF_BAUD_LSB = 8;
  localparam int CF_BAUDOK   = 11;
  localparam int CF_FROMPC   = 12;

  // Baud rate selections and switch patterns {sw4,sw3,sw2,sw1}
  localparam logic [2:0] BAUD_50   = 3'h0;
  localparam logic [2:0] BAUD_125  = 3'h1;
  localparam logic [2:0] BAUD_250  = 3'h2;
  localparam logic [2:0] BAUD_500  = 3'h3;
  localparam logic [2:0] BAUD_1000 = 3'h4;
  localparam logic [3:0] BSW_50    = 4'h0;
  localparam logic [3:0] BSW_125   = 4'h2;
  localparam logic [3:0] BSW_250   = 4'h3;
  localparam logic [3:0] BSW_500   = 4'h4;
  localparam logic [3:0] BSW_1000  = 4'h5;

  typedef enum logic [2:0] {
    DPSM_NOT_READY,
    DPSM_SW_DISABLED,
    DPSM_READY,
    DPSM_SWITCHED_ON,
    DPSM_OP_ENABLED,
    DPSM_QSTOP,
    DPSM_FAULT_REACT,
    DPSM_FAULT
  } dpsm_state_t;

endpackage

// ===== design/dpsm_sw_decode.sv
// Decoder for the node address and baud rate DIP switches.
// Assumes switch inputs are static or synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module dpsm_sw_decode
  import dpsm_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  // Switches and software address
  input  wire logic [6:0] addr_sw,
  input  wire logic       addr_sw_fitted,
  input  wire logic [3:0] baud_sw,
  input  wire logic [6:0] pc_node,
  // Decoded results
  dpsm_cfg_if.dec         cfg
);

  logic       use_pc;
  logic [6:0] next_node;

  // Software address only counts with no switches fitted or all off
  assign use_pc    = !addr_sw_fitted || (addr_sw == 7'h00);
  assign next_node = use_pc ? pc_node : addr_sw;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cfg.node_id <= 7'h00;
      cfg.node_ok <= 1'b0;
      cfg.from_pc <= 1'b0;
    end
    else if (ce)
    begin
      cfg.node_id <= next_node;
      // Node 0 is the broadcast address and never valid
      cfg.node_ok <= (next_node != 7'h00);
      cfg.from_pc <= use_pc;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cfg.baud_sel <= BAUD_50;
      cfg.baud_ok  <= 1'b0;
    end
    else if (ce)
    begin
      cfg.baud_ok <= 1'b1;
      case (baud_sw)
        BSW_50:   cfg.baud_sel <= BAUD_50;
        BSW_125:  cfg.baud_sel <= BAUD_125;
        BSW_250:  cfg.baud_sel <= BAUD_250;
        BSW_500:  cfg.baud_sel <= BAUD_500;
        BSW_1000: cfg.baud_sel <= BAUD_1000;
        default:
        begin
          cfg.baud_sel <= BAUD_50;
          cfg.baud_ok  <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== design/dpsm_top.sv
// Drive power state machine with APB register access.
// Assumes drive status inputs are synchronous to core_clk.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dpsm_top
  import dpsm_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [dpsm_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [dpsm_pkg::DATA_W-1:0]   pwdata,
  output var  logic [dpsm_pkg::DATA_W-1:0]   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // Drive status
  input  wire logic                          self_test_done,
  input  wire logic                          self_test_ok,
  input  wire logic                          fault_active,
  input  wire logic                          quick_stop_done,
  input  wire logic                          fault_react_done,
  // Switches
  input  wire logic [6:0]                    addr_sw,
  input  wire logic                          addr_sw_fitted,
  input  wire logic [3:0]                    baud_sw,
  // Drive controls
  output var  logic                          comm_active,
  output var  logic                          power_stage_on,
  output var  logic                          drive_enable,
  output var  logic                          quick_stop_run,
  output var  logic                          fault_react_run,
  output var  logic                          param_write_ok,
  output var  logic [2:0]                    state_code,
  // Bus settings
  output var  logic [6:0]                    node_id,
  output var  logic                          node_id_valid,
  output var  logic [2:0]                    baud_sel,
  output var  logic                          baud_valid
);

  dpsm_cfg_if cfg_bus ();

  dpsm_state_t  state;
  dpsm_state_t  next_state;
  logic         cmd_pend;
  logic [2:0]   cmd_code;
  logic [2:0]   last_cmd;
  logic [2:0]   cmd;
  logic [15:0]  qs_opt;
  logic [6:0]   pc_node;
  logic         param_hold;
  logic         apb_access;
  logic         apb_done;
  logic         wr_done;
  logic         addr_hit;
  logic [31:0]  next_rdata;
  logic         qs_may_return;

  dpsm_sw_decode u_dec
  (
    .core_clk       (core_clk),
    .rst_b          (rst_b),
    .ce             (ce),
    .addr_sw        (addr_sw),
    .addr_sw_fitted (addr_sw_fitted),
    .baud_sw        (baud_sw),
    .pc_node        (pc_node),
    .cfg            (cfg_bus.dec)
  );

  assign node_id       = cfg_bus.node_id;
  assign node_id_valid = cfg_bus.node_ok;
  assign baud_sel      = cfg_bus.baud_sel;
  assign baud_valid    = cfg_bus.baud_ok;

  // APB handshake: one wait state, longer while a command is pending
  assign apb_access    = psel && penable;
  assign apb_done      = apb_access && pready;
  assign wr_done       = apb_done && pwrite;
  assign cmd           = cmd_pend ? cmd_code : CMD_NONE;
  assign qs_may_return = (qs_opt >= QSOPT_RET_MIN) && (qs_opt <= QSOPT_RET_MAX);

  always_comb
  begin
    addr_hit   = 1'b1;
    next_rdata = 32'h0000_0000;
    if (paddr == OFF_CMD)
      next_rdata[2:0] = last_cmd;
    else if (paddr == OFF_QSOPT)
      next_rdata[15:0] = qs_opt;
    else if (paddr == OFF_STATUS)
    begin
      next_rdata[ST_STATE_LSB +: 3] = state;
      next_rdata[ST_POWER]          = power_stage_on;
      next_rdata[ST_DRIVE]          = drive_enable;
      next_rdata[ST_QSRUN]          = quick_stop_run;
      next_rdata[ST_FRRUN]          = fault_react_run;
      next_rdata[ST_COMM]           = comm_active;
      next_rdata[ST_FAULTIN]        = fault_active;
      next_rdata[ST_PARAMOK]        = param_write_ok;
    end
    else if (paddr == OFF_CONFIG)
    begin
      next_rdata[CF_NODE_LSB +: 7] = cfg_bus.node_id;
      next_rdata[CF_NODEOK]        = cfg_bus.node_ok;
      next_rdata[CF_BAUD_LSB +: 3] = cfg_bus.baud_sel;
      next_rdata[CF_BAUDOK]        = cfg_bus.baud_ok;
      next_rdata[CF_FROMPC]        = cfg_bus.from_pc;
    end
    else if (paddr == OFF_PCNODE)
      next_rdata[6:0] = pc_node;
    else if (paddr == OFF_PARAM)
    begin
      next_rdata[0] = param_hold;
      next_rdata[1] = param_write_ok;
    end
    else
      addr_hit = 1'b0;
  end

  // Reads only sample state; they never feed the state machine
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      // Holding pready off while a command is pending keeps commands serial
      pready  <= apb_access && !pready && !cmd_pend;
      pslverr <= apb_access && !pready && !addr_hit;
      prdata  <= (apb_access && !pready && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  // Software configuration registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      qs_opt  <= QSOPT_RST;
      pc_node <= PCNODE_RST;
    end
    else if (ce && wr_done)
    begin
      if (paddr == OFF_QSOPT)
        qs_opt <= pwdata[15:0];
      else if (paddr == OFF_PCNODE)
        pc_node <= pwdata[6:0];
    end
  end

  // Command capture; a parameter request injects a disable-voltage
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      cmd_pend   <= 1'b0;
      cmd_code   <= CMD_NONE;
      last_cmd   <= CMD_NONE;
      param_hold <= 1'b0;
    end
    else if (ce)
    begin
      cmd_pend <= 1'b0;
      if (wr_done && paddr == OFF_CMD && pwdata[2:0] != CMD_NONE)
      begin
        cmd_pend <= 1'b1;
        cmd_code <= pwdata[2:0];
        last_cmd <= pwdata[2:0];
      end
      else if (wr_done && paddr == OFF_PARAM)
      begin
        param_hold <= pwdata[0];
        if (pwdata[0])
        begin
          cmd_pend <= 1'b1;
          cmd_code <= CMD_DISVOLT;
        end
      end
    end
  end

  always_comb
  begin
    next_state = state;
    case (state)
      DPSM_NOT_READY:
        if (self_test_done && self_test_ok)
          next_state = DPSM_SW_DISABLED;
      DPSM_SW_DISABLED:
        if (cmd == CMD_SHUTDOWN)
          next_state = DPSM_READY;
      DPSM_READY:
        if (cmd == CMD_SWON && !param_hold)
          next_state = DPSM_SWITCHED_ON;
        else if (cmd == CMD_QSTOP || cmd == CMD_DISVOLT)
          next_state = DPSM_SW_DISABLED;
      DPSM_SWITCHED_ON:
        if (cmd == CMD_SHUTDOWN)
          next_state = DPSM_READY;
        else if (cmd == CMD_ENOP)
          next_state = DPSM_OP_ENABLED;
        else if (cmd == CMD_DISVOLT || cmd == CMD_QSTOP)
          next_state = DPSM_SW_DISABLED;
      DPSM_OP_ENABLED:
        if (cmd == CMD_DISOP)
          next_state = DPSM_SWITCHED_ON;
        else if (cmd == CMD_SHUTDOWN)
          next_state = DPSM_READY;
        else if (cmd == CMD_DISVOLT)
          next_state = DPSM_SW_DISABLED;
        else if (cmd == CMD_QSTOP)
          next_state = DPSM_QSTOP;
      DPSM_QSTOP:
        if (qs_opt != QSOPT_STAY && (quick_stop_done || cmd == CMD_DISVOLT))
          next_state = DPSM_SW_DISABLED;
        else if (cmd == CMD_ENOP && qs_may_return)
          next_state = DPSM_OP_ENABLED;
      DPSM_FAULT_REACT:
        if (fault_react_done)
          next_state = DPSM_FAULT;
      DPSM_FAULT:
        if (cmd == CMD_FRESET && !fault_active)
          next_state = DPSM_SW_DISABLED;
      default:
        next_state = DPSM_NOT_READY;
    endcase
    // A fault overrides any command taken in the same cycle
    if (fault_active && state != DPSM_FAULT_REACT && state != DPSM_FAULT)
      next_state = DPSM_FAULT_REACT;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      state <= DPSM_NOT_READY;
    else if (ce)
      state <= next_state;
  end

  // Drive controls follow the state being entered
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      comm_active     <= 1'b0;
      power_stage_on  <= 1'b0;
      drive_enable    <= 1'b0;
      quick_stop_run  <= 1'b0;
      fault_react_run <= 1'b0;
      param_write_ok  <= 1'b0;
      state_code      <= 3'h0;
    end
    else if (ce)
    begin
      comm_active     <= comm_active || (next_state != DPSM_NOT_READY);
      // Power stays on through fault reaction; it drops on reaching fault
      power_stage_on  <= (next_state == DPSM_SWITCHED_ON) || (next_state == DPSM_OP_ENABLED)
                         || (next_state == DPSM_QSTOP)
                         || (next_state == DPSM_FAULT_REACT && power_stage_on);
      drive_enable    <= (next_state == DPSM_OP_ENABLED);
      quick_stop_run  <= (next_state == DPSM_QSTOP);
      fault_react_run <= (next_state == DPSM_FAULT_REACT);
      param_write_ok  <= param_hold && (next_state == DPSM_SW_DISABLED);
      state_code      <= next_state;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  a_selftest_exit: assert property (
    (ce && state == DPSM_NOT_READY && self_test_done && self_test_ok && !fault_active)
    |=> (state == DPSM_SW_DISABLED) && comm_active)
    else $error("self-test exit not taken");

  a_shutdown_ready: assert property (
    (ce && cmd == CMD_SHUTDOWN && !fault_active
     && (state == DPSM_SW_DISABLED || state == DPSM_SWITCHED_ON || state == DPSM_OP_ENABLED))
    |=> (state == DPSM_READY) && !power_stage_on)
    else $error("shutdown did not reach ready");

  a_switch_on_power: assert property (
    (ce && state == DPSM_READY && cmd == CMD_SWON && !param_hold && !fault_active)
    |=> (state == DPSM_SWITCHED_ON) && power_stage_on && !drive_enable)
    else $error("switch-on did not power the stage");

  a_enable_op_drive: assert property (
    (ce && state == DPSM_SWITCHED_ON && cmd == CMD_ENOP && !fault_active)
    |=> (state == DPSM_OP_ENABLED) && drive_enable)
    else $error("enable operation failed");

  a_disable_op_drive: assert property (
    (ce && state == DPSM_OP_ENABLED && cmd == CMD_DISOP && !fault_active)
    |=> (state == DPSM_SWITCHED_ON) && !drive_enable && power_stage_on)
    else $error("disable operation failed");

  a_ready_disable: assert property (
    (ce && state == DPSM_READY && !fault_active && (cmd == CMD_QSTOP || cmd == CMD_DISVOLT))
    |=> state == DPSM_SW_DISABLED)
    else $error("ready did not drop to switch-on disabled");

  a_op_voltage_off: assert property (
    (ce && state == DPSM_OP_ENABLED && cmd == CMD_DISVOLT && !fault_active)
    |=> (state == DPSM_SW_DISABLED) && !power_stage_on)
    else $error("disable voltage left power on");

  a_quick_stop_entry: assert property (
    (ce && state == DPSM_OP_ENABLED && cmd == CMD_QSTOP && !fault_active)
    |=> (state == DPSM_QSTOP) && quick_stop_run && !drive_enable)
    else $error("quick stop not entered");

  a_quick_stop_stay: assert property (
    (ce && state == DPSM_QSTOP && qs_opt == QSOPT_STAY && !fault_active && cmd != CMD_ENOP)
    |=> state == DPSM_QSTOP)
    else $error("quick stop left with option 5");

  a_fault_entry: assert property (
    (ce && fault_active && state != DPSM_FAULT_REACT && state != DPSM_FAULT)
    |=> (state == DPSM_FAULT_REACT) && fault_react_run)
    else $error("fault did not start fault reaction");

  a_fault_hold: assert property (
    (state == DPSM_FAULT && fault_active) |=> state == DPSM_FAULT)
    else $error("fault state left while fault active");

  a_cmd_serial: assert property (
    (ce && cmd_pend) |=> !cmd_pend && !pready)
    else $error("command pending across two cycles");

  a_state_report: assert property (
    (ce && state != next_state) |=> state_code == $past(next_state))
    else $error("state output not updated");

endmodule
`default_nettype wire

// ===== sim/dpsm_drive_model.sv
// Drive hardware model: self-test sequencer, quick stop ramp, fault reaction.
// Assumes it shares core_clk and rst_b with the state machine.
`timescale 1ns/1ps
`default_nettype none
module dpsm_drive_model
#(
  parameter int ST_LAT = 30,
  parameter int QS_LAT = 24,
  parameter int FR_LAT = 24
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Requests
  input  wire logic quick_stop_run,
  input  wire logic fault_react_run,
  // Reports
  output var  logic self_test_done,
  output var  logic self_test_ok,
  output var  logic quick_stop_done,
  output var  logic fault_react_done
);
  int st_cnt;
  int qs_cnt;
  int fr_cnt;
  always_ff @(posedge core_clk)
    st_cnt <= !rst_b ? 0 : (st_cnt < ST_LAT) ? st_cnt + 1 : st_cnt;
  always_ff @(posedge core_clk)
    qs_cnt <= (!rst_b || !quick_stop_run) ? 0 : qs_cnt + 1;
  always_ff @(posedge core_clk)
    fr_cnt <= (!rst_b || !fault_react_run) ? 0 : fr_cnt + 1;
  assign self_test_done = (st_cnt == ST_LAT);
  // Ok flickers before done, so the design must qualify it with done
  assign self_test_ok = self_test_done | st_cnt[0];
  assign quick_stop_done = quick_stop_run && qs_cnt >= QS_LAT;
  assign fault_react_done = fault_react_run && fr_cnt >= FR_LAT;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Testbench: APB driver with expected-value queue, read monitor, drive model.
// Assumes the design package, design and drive model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dpsm_pkg::*;
  logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rnd = 32'd93469;
  logic fault_active = 0, addr_sw_fitted = 0, comm = 0, pok = 0, hw, ce = 1;
  logic comm_o, pwr_o, drv_o, pok_o, nok_o, bok_o;
  logic [2:0] state_o, baud_o;
  logic [6:0] node_o;
  logic [32:0] exp_note;
  logic [6:0] addr_sw = 0, nd;
  logic [3:0] baud_sw = 0;
  logic pready, pslverr, st_done, st_ok, qs_done, fr_done, qs_run, fr_run;
  logic [32:0] expq[$];
  logic [7:0] seq [24] = '{8'h44, 8'hE4, 8'h28, 8'hC8, 8'h4E, 8'hD3, 8'hAE, 8'h28,
    8'h4E, 8'hD3, 8'h28, 8'h84, 8'h28, 8'h64, 8'h28, 8'h4E, 8'h64, 8'h28, 8'h4E,
    8'h84, 8'h28, 8'h4E, 8'hD3, 8'h64};
  logic [3:0] bsw [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
  logic [2:0] bcd [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
  int n_errors = 0;
  int num_checks = 0;
  always #5 core_clk = ~core_clk;
  dpsm_top uut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .self_test_done(st_done),
    .self_test_ok(st_ok), .fault_active(fault_active), .quick_stop_done(qs_done),
    .fault_react_done(fr_done), .addr_sw(addr_sw), .addr_sw_fitted(addr_sw_fitted),
    .baud_sw(baud_sw), .comm_active(comm_o), .power_stage_on(pwr_o), .drive_enable(drv_o),
    .quick_stop_run(qs_run), .fault_react_run(fr_run), .param_write_ok(pok_o),
    .state_code(state_o), .node_id(node_o), .node_id_valid(nok_o), .baud_sel(baud_o),
    .baud_valid(bok_o));
  dpsm_drive_model drv (.core_clk(core_clk), .rst_b(rst_b), .quick_stop_run(qs_run),
    .fault_react_run(fr_run), .self_test_done(st_done), .self_test_ok(st_ok),
    .quick_stop_done(qs_done), .fault_react_done(fr_done));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] st(input logic [2:0] s, input logic p, input logic d);
    st = {23'h0, pok && s == 3'h1, fault_active, comm, s == 3'h6, s == 3'h5, d, p, s};
  endfunction
  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic cmp_pins(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch t=%0t pins exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
    expq.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task automatic chk(input logic [2:0] c, input logic [2:0] s, input logic p, input logic d);
    wr(OFF_CMD, {29'h0, c});
    rd(OFF_STATUS, st(s, p, d));
  endtask
  task automatic up3;
    chk(CMD_SHUTDOWN, 3'h2, 1'b0, 1'b0);
    chk(CMD_SWON, 3'h3, 1'b1, 1'b0);
    chk(CMD_ENOP, 3'h4, 1'b1, 1'b1);
  endtask
  // Write data is not returned, so only pslverr is compared on writes
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && expq.size() > 0)
    begin
      exp_note = expq.pop_front();
      cmp(exp_note, {pslverr, pwrite ? 32'h0 : prdata});
      // Drive pins must agree with what the status and config reads promise
      if (!pwrite && paddr == OFF_STATUS)
        cmp_pins({23'h0, exp_note[9], exp_note[7:0]},
                 {23'h0, pok_o, comm_o, fr_run, qs_run, drv_o, pwr_o, state_o});
      if (!pwrite && paddr == OFF_CONFIG)
        cmp_pins({20'h0, exp_note[11:0]}, {20'h0, bok_o, baud_o, nok_o, node_o});
    end
  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(OFF_STATUS, 32'h0);
    rd(OFF_QSOPT, 32'h2);
    rd(OFF_PCNODE, 32'h1);
    xfer(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, 8'h1C, 32'h5, {1'b1, 32'h0});
    repeat (40) @(posedge core_clk);
    comm = 1'b1;
    rd(OFF_STATUS, st(3'h1, 1'b0, 1'b0));
    foreach (seq[i])
      chk(seq[i][7:5], seq[i][4:2], seq[i][1], seq[i][0]);
    wr(OFF_QSOPT, 32'h5);
    rd(OFF_QSOPT, 32'h5);
    up3();
    chk(CMD_QSTOP, 3'h5, 1'b1, 1'b0);
    repeat (30) @(posedge core_clk);
    rd(OFF_STATUS, st(3'h5, 1'b1, 1'b0));
    chk(CMD_ENOP, 3'h4, 1'b1, 1'b1);
    wr(OFF_QSOPT, 32'h2);
    chk(CMD_QSTOP, 3'h5, 1'b1, 1'b0);
    chk(CMD_ENOP, 3'h5, 1'b1, 1'b0);
    repeat (30) @(posedge core_clk);
    rd(OFF_STATUS, st(3'h1, 1'b0, 1'b0));
    up3();
    fault_active <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(OFF_STATUS, st(3'h6, 1'b1, 1'b0));
    repeat (30) @(posedge core_clk);
    chk(CMD_FRESET, 3'h7, 1'b0, 1'b0);
    fault_active <= 1'b0;
    @(posedge core_clk);
    chk(CMD_FRESET, 3'h1, 1'b0, 1'b0);
    wr(OFF_CMD, 32'h0);
    up3();
    // A fault seen only while the clock enable is low must leave the state frozen
    ce <= 1'b0;
    fault_active <= 1'b1;
    repeat (4) @(posedge core_clk);
    ce <= 1'b1;
    fault_active <= 1'b0;
    @(posedge core_clk);
    rd(OFF_STATUS, st(3'h4, 1'b1, 1'b1));
    pok = 1'b1;
    wr(OFF_PARAM, 32'h1);
    rd(OFF_STATUS, st(3'h1, 1'b0, 1'b0));
    chk(CMD_SWON, 3'h1, 1'b0, 1'b0);
    rd(OFF_PARAM, 32'h3);
    pok = 1'b0;
    wr(OFF_PARAM, 32'h0);
    for (int i = 0; i < 24; i++)
    begin
      rnd = lfsr(rnd);
      addr_sw <= rnd[6:0];
      addr_sw_fitted <= rnd[7];
      baud_sw <= bsw[i % 6];
      hw = rnd[7] && rnd[6:0] != 7'h00;
      nd = hw ? rnd[6:0] : rnd[14:8];
      wr(OFF_PCNODE, {25'h0, rnd[14:8]});
      rd(OFF_CONFIG, {19'h0, !hw, i % 6 != 5, bcd[i % 6], nd != 7'h00, nd});
    end
    end_sim();
  end
endmodule
`default_nettype wire
